// [csr_regs.sv]
// register file for can status, interrupt flags, fifo pointers and error counters
// assumes an apb master at pclk and a protocol engine driving event pulses
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none
`include "csr_cfg.svh"
module csr_regs
    import csr_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic [2:0]     op_mode,
    input  wire csr_err_state_t err_state,
    input  wire csr_events_t    events,
    input  wire csr_cnt_upd_t   cnt_upd,
    input  wire logic           filter_hit_valid,
    input  wire logic [4:0]     filter_hit,
    input  wire logic [4:0]     compare_len_in,
    input  wire logic           compare_len_load,
    input  wire logic           fifo_write_adv,
    input  wire logic           fifo_read_adv,
    output logic      [4:0]     data_bit_compare_count,
    output logic      [2:0]     buffer_area_size,
    output logic      [5:0]     buffer_count,
    output logic      [4:0]     fifo_first_buffer,
    output logic                irq
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        csr_bus_st_t bus;
        logic [31:0] rdata;
        logic        err;
        logic [4:0]  cmp_len;
        logic [4:0]  hit;
        logic [2:0]  size;
        logic [4:0]  first;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [15:0] buf_pend;
        logic [7:0]  tx_cnt;
        logic [7:0]  rx_cnt;
        logic [2:0]  mode_q;
        logic [4:0]  err_q;
    } csr_st_t;

    csr_st_t     st;
    csr_st_t     next_st;
    csr_apb_req_t req;
    logic [6:0]  code;
    logic [5:0]  wr_ptr;
    logic [5:0]  rd_ptr;
    logic        any_warning;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clr;
    logic [15:0] buf_set;
    logic        wr_en;
    logic        rd_en;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                   pwdata: pwdata};

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        unique case (a)
            `CSR_OFS_CMP_LEN, `CSR_OFS_VECTOR, `CSR_OFS_FIFO_CTL, `CSR_OFS_FIFO_PTR,
            `CSR_OFS_FLAGS, `CSR_OFS_ENABLES, `CSR_OFS_ERR_CNT: mapped = 1'b1;
            default:                                            mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [5:0] area_size(input logic [2:0] s);
        unique case (s)
            3'h0:    area_size = 6'd4;
            3'h1:    area_size = 6'd6;
            3'h2:    area_size = 6'd8;
            3'h3:    area_size = 6'd12;
            3'h4:    area_size = 6'd16;
            3'h5:    area_size = 6'd24;
            default: area_size = 6'd32;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // submodules
    // -----------------------------------------------------------------
    csr_prio u_prio (
        .flags       (st.flags & st.enables),
        .buf_pending (st.buf_pend & {16{st.flags[`CSR_BIT_RX] | st.flags[`CSR_BIT_TX]}}),
        .code        (code)
    );

    csr_fifo_ptr u_ptr (
        .pclk               (pclk),
        .presetn            (presetn),
        .first_buffer       (st.first),
        .last_buffer        (area_size(st.size) - 6'd1),
        .write_adv          (fifo_write_adv),
        .read_adv           (fifo_read_adv),
        .fifo_write_pointer (wr_ptr),
        .fifo_read_pointer  (rd_ptr)
    );

    // -----------------------------------------------------------------
    // event logic
    // -----------------------------------------------------------------
    assign any_warning = err_state.tx_warning | err_state.rx_warning;
    assign wr_en = req.psel & req.penable & req.pwrite & (st.bus == CSR_ACCESS) & ~st.err;
    assign rd_en = req.psel & ~req.penable & ~req.pwrite;

    always_comb begin
        flag_set = 8'h00;
        flag_set[`CSR_BIT_INVALID] = events.invalid_message;
        flag_set[`CSR_BIT_WAKE]    = events.wake_activity;
        // a new error source raises the error flag
        flag_set[`CSR_BIT_ERROR]   = |({err_state, any_warning} & ~{st.err_q, 1'b1})
                                     | (any_warning & ~(st.err_q[1] | st.err_q[0]));
        flag_set[`CSR_BIT_FIFO]    = events.fifo_almost_full;
        flag_set[`CSR_BIT_OVFL]    = events.rx_overflow;
        flag_set[`CSR_BIT_RX]      = events.rx_buffer;
        flag_set[`CSR_BIT_TX]      = events.tx_buffer;
        flag_set = flag_set & `CSR_FLAG_MASK;
        flag_clr = 8'h00;
        if (wr_en && req.paddr == `CSR_OFS_FLAGS && pstrb[0]) begin
            flag_clr = ~req.pwdata[7:0] & `CSR_FLAG_MASK;
        end
        buf_set = 16'h0000;
        if (events.rx_buffer || events.tx_buffer) begin
            buf_set[events.buffer_index] = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.mode_q = op_mode;
        next_st.err_q  = err_state;
        // set wins over a clear in the same cycle
        next_st.flags = (st.flags & ~flag_clr) | flag_set;
        if (flag_clr[`CSR_BIT_RX] || flag_clr[`CSR_BIT_TX]) begin
            next_st.buf_pend = buf_set;
        end else begin
            next_st.buf_pend = st.buf_pend | buf_set;
        end
        if (filter_hit_valid && filter_hit <= `CSR_FILT_MAX) begin
            next_st.hit = filter_hit;
        end
        if (compare_len_load && compare_len_in <= `CSR_CMP_LEN_MAX) begin
            next_st.cmp_len = compare_len_in;
        end
        if (cnt_upd.tx_load) begin
            next_st.tx_cnt = cnt_upd.tx_value;
        end
        if (cnt_upd.rx_load) begin
            next_st.rx_cnt = cnt_upd.rx_value;
        end
        // counters cleared on entry to configuration mode
        if (op_mode == `CSR_MODE_CONFIG && st.mode_q != `CSR_MODE_CONFIG) begin
            next_st.tx_cnt = 8'h00;
            next_st.rx_cnt = 8'h00;
        end
        if (wr_en && req.paddr == `CSR_OFS_FIFO_CTL) begin
            if (pstrb[1] && req.pwdata[15:13] != `CSR_SIZE_RSVD) begin
                next_st.size = req.pwdata[15:13];
            end
            if (pstrb[0]) begin
                next_st.first = req.pwdata[4:0];
            end
        end
        if (wr_en && req.paddr == `CSR_OFS_ENABLES && pstrb[0]) begin
            next_st.enables = req.pwdata[7:0] & `CSR_FLAG_MASK;
        end
        // apb sequencing: setup, access (ready), done
        unique case (st.bus)
            CSR_IDLE: begin
                if (req.psel && !req.penable) begin
                    next_st.bus = CSR_ACCESS;
                    next_st.err = ~mapped(req.paddr);
                end
            end
            CSR_ACCESS: begin
                next_st.bus = CSR_DONE;
            end
            CSR_DONE: begin
                next_st.bus = CSR_IDLE;
                next_st.err = 1'b0;
                if (req.psel && !req.penable) begin
                    next_st.bus = CSR_ACCESS;
                    next_st.err = ~mapped(req.paddr);
                end
            end
        endcase
        // read data captured in setup; unused bits are zero
        if (rd_en) begin
            unique case (req.paddr)
                `CSR_OFS_CMP_LEN:  next_st.rdata = {27'h0, st.cmp_len};
                `CSR_OFS_VECTOR:   next_st.rdata = {19'h0, st.hit, 1'b0, code};
                `CSR_OFS_FIFO_CTL: next_st.rdata = {16'h0, st.size, 8'h0, st.first};
                `CSR_OFS_FIFO_PTR: next_st.rdata = {18'h0, wr_ptr, 2'b0, rd_ptr};
                `CSR_OFS_FLAGS:    next_st.rdata = {18'h0, err_state, any_warning,
                                                    st.flags};
                `CSR_OFS_ENABLES:  next_st.rdata = {24'h0, st.enables};
                `CSR_OFS_ERR_CNT:  next_st.rdata = {16'h0, st.tx_cnt, st.rx_cnt};
                default:           next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{bus: CSR_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign pready                 = (st.bus == CSR_ACCESS);
    assign pslverr                = (st.bus == CSR_ACCESS) & st.err;
    assign prdata                 = st.rdata;
    assign data_bit_compare_count = st.cmp_len;
    assign buffer_area_size       = st.size;
    assign buffer_count           = area_size(st.size);
    assign fifo_first_buffer      = st.first;
    assign irq                    = |(st.flags & st.enables);
endmodule
`default_nettype wire

// [csr_cfg.svh]
// constants for the can status, interrupt, fifo pointer and error count register block
// assumes apb with 32-bit data, one aligned word per register
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

`define CSR_OFS_CMP_LEN   12'h000
`define CSR_OFS_VECTOR    12'h004
`define CSR_OFS_FIFO_CTL  12'h008
`define CSR_OFS_FIFO_PTR  12'h00c
`define CSR_OFS_FLAGS     12'h010
`define CSR_OFS_ENABLES   12'h014
`define CSR_OFS_ERR_CNT   12'h018

`define CSR_CMP_LEN_MAX   5'h11
`define CSR_FLAG_MASK     8'hef
`define CSR_FIFO_CTL_MASK 16'he01f
`define CSR_SIZE_RSVD     3'h7
`define CSR_CODE_NONE     7'h40
`define CSR_CODE_ERROR    7'h41
`define CSR_CODE_WAKE     7'h42
`define CSR_CODE_OVFL     7'h43
`define CSR_CODE_FIFO     7'h44
`define CSR_FILT_MAX      5'h0f
`define CSR_BUF_CODE_MAX  5'h0f
`define CSR_PTR_MAX       6'h1f
`define CSR_MODE_CONFIG   3'h4
`define CSR_MODE_DISABLE  3'h1

`define CSR_BIT_INVALID   3'd7
`define CSR_BIT_WAKE      3'd6
`define CSR_BIT_ERROR     3'd5
`define CSR_BIT_FIFO      3'd3
`define CSR_BIT_OVFL      3'd2
`define CSR_BIT_RX        3'd1
`define CSR_BIT_TX        3'd0
`endif

// [csr_pkg.sv]
// types shared by the can status register block
// assumes csr_cfg.svh is on the include path
`default_nettype none
package csr_pkg;
    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } csr_apb_req_t;

    // error state of the protocol engine
    typedef struct packed {
        logic       tx_bus_off;
        logic       tx_error_passive;
        logic       rx_error_passive;
        logic       tx_warning;
        logic       rx_warning;
    } csr_err_state_t;

    // one-cycle event pulses from the protocol engine
    typedef struct packed {
        logic       invalid_message;
        logic       wake_activity;
        logic       fifo_almost_full;
        logic       rx_overflow;
        logic       rx_buffer;
        logic       tx_buffer;
        logic [3:0] buffer_index;
    } csr_events_t;

    // error counter updates from the protocol engine
    typedef struct packed {
        logic       tx_load;
        logic [7:0] tx_value;
        logic       rx_load;
        logic [7:0] rx_value;
    } csr_cnt_upd_t;

    typedef enum logic [2:0] {
        CSR_IDLE   = 3'b001,
        CSR_ACCESS = 3'b010,
        CSR_DONE   = 3'b100
    } csr_bus_st_t;
endpackage
`default_nettype wire

// [csr_prio.sv]
// fixed priority encoder producing the interrupt source code
// assumes flags already masked by their enables
`default_nettype none
`include "csr_cfg.svh"
module csr_prio
    import csr_pkg::*;
(
    input  wire logic [7:0]  flags,
    input  wire logic [15:0] buf_pending,
    output logic      [6:0]  code
);
    // error, wake, overflow, fifo, then lowest buffer number
    always_comb begin
        code = `CSR_CODE_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (buf_pending[i]) begin
                code = {3'h0, 4'(i)};
            end
        end
        if (flags[`CSR_BIT_FIFO]) begin
            code = `CSR_CODE_FIFO;
        end
        if (flags[`CSR_BIT_OVFL]) begin
            code = `CSR_CODE_OVFL;
        end
        if (flags[`CSR_BIT_WAKE]) begin
            code = `CSR_CODE_WAKE;
        end
        if (flags[`CSR_BIT_ERROR]) begin
            code = `CSR_CODE_ERROR;
        end
    end
endmodule
`default_nettype wire

// [csr_fifo_ptr.sv]
// receive fifo write and read pointers over the buffer area
// assumes advance strobes are one-cycle pulses
`default_nettype none
`include "csr_cfg.svh"
module csr_fifo_ptr
    import csr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [4:0] first_buffer,
    input  wire logic [5:0] last_buffer,
    input  wire logic       write_adv,
    input  wire logic       read_adv,
    output logic      [5:0] fifo_write_pointer,
    output logic      [5:0] fifo_read_pointer
);
    typedef struct packed {
        logic [5:0] wr;
        logic [5:0] rd;
    } csr_ptr_st_t;

    csr_ptr_st_t st;
    csr_ptr_st_t next_st;

    function automatic logic [5:0] step(input logic [5:0] p, input logic [4:0] first,
                                        input logic [5:0] last);
        if (p >= last || p >= `CSR_PTR_MAX || p < {1'b0, first}) begin
            step = {1'b0, first};
        end else begin
            step = p + 6'h01;
        end
    endfunction

    always_comb begin
        next_st = st;
        if (write_adv) begin
            next_st.wr = step(st.wr, first_buffer, last_buffer);
        end
        if (read_adv) begin
            next_st.rd = step(st.rd, first_buffer, last_buffer);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fifo_write_pointer = st.wr;
    assign fifo_read_pointer  = st.rd;
endmodule
`default_nettype wire

// [csr_chk.sv]
// concurrent checks on the port side of the can status register block
// assumes it is bound to csr_regs, with pclk and presetn as its only domain
`default_nettype none
`include "csr_cfg.svh"
module csr_chk
    import csr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  compare_len_in,
    input wire logic        compare_len_load,
    input wire logic [4:0]  data_bit_compare_count,
    input wire logic [2:0]  buffer_area_size,
    input wire logic [5:0]  buffer_count,
    input wire logic [4:0]  fifo_first_buffer,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] size_tbl [8] = '{6'h04, 6'h06, 6'h08, 6'h0c,
                                            6'h10, 6'h18, 6'h20, 6'h00};
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    chk_err_map: assert property (pready |-> pslverr ==
        (paddr > `CSR_OFS_ERR_CNT || paddr[1:0] != 2'h0)) else $error("bad slave error");
    chk_size_table: assert property (buffer_area_size != `CSR_SIZE_RSVD &&
        buffer_count == size_tbl[buffer_area_size]) else $error("bad buffer count");
    chk_len_load: assert property (compare_len_load &&
        compare_len_in <= `CSR_CMP_LEN_MAX |=> data_bit_compare_count == $past(compare_len_in))
        else $error("compare length not loaded");
    chk_len_keep: assert property (compare_len_load &&
        compare_len_in > `CSR_CMP_LEN_MAX |=> $stable(data_bit_compare_count))
        else $error("invalid compare length taken");
    chk_vec_legal: assert property (rd_ok && paddr == `CSR_OFS_VECTOR |->
        prdata[31:12] == 20'h0 && !prdata[7] &&
        (prdata[6:0] <= 7'h0f || prdata[6:0] inside {[7'h40:7'h44]}))
        else $error("reserved vector code");
    chk_flag_bits: assert property (rd_ok && paddr == `CSR_OFS_FLAGS |->
        prdata[31:14] == 18'h0 && !prdata[4] && prdata[8] == (prdata[10] || prdata[9]))
        else $error("bad flag word");
    chk_ptr_bits: assert property (rd_ok && paddr == `CSR_OFS_FIFO_PTR |->
        (prdata & 32'hffffe0e0) == 32'h0) else $error("pointer out of range");
    chk_first_wr: assert property (pready && penable && pwrite && !pslverr &&
        paddr == `CSR_OFS_FIFO_CTL && pstrb[0] |=> fifo_first_buffer == $past(pwdata[4:0]))
        else $error("first buffer not written");
    chk_irq_off: assert property (rd_ok && paddr == `CSR_OFS_ENABLES &&
        prdata == 32'h0 |-> !irq) else $error("irq with all enables off");
endmodule
`default_nettype wire

// [csr_engine_model.sv]
// stand-in for the protocol engine and the bus nodes behind it
// assumes the bench calls its tasks from one process, just after an edge
`default_nettype none
module csr_engine_model
    import csr_pkg::*;
(
    input  wire logic           pclk,
    output var logic [2:0]      op_mode,
    output var csr_err_state_t  err_state,
    output var csr_events_t     events,
    output var csr_cnt_upd_t    cnt_upd,
    output var logic            filter_hit_valid,
    output var logic [4:0]      filter_hit,
    output var logic [4:0]      compare_len_in,
    output var logic            compare_len_load,
    output var logic            fifo_write_adv,
    output var logic            fifo_read_adv
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {op_mode, err_state, events, cnt_upd} = '0;
        {filter_hit_valid, filter_hit, compare_len_in, compare_len_load} = '0;
        {fifo_write_adv, fifo_read_adv} = '0;
    end
    task automatic lvl(input logic [4:0] s, input logic [2:0] m);
        @(posedge pclk);
        err_state <= s;
        op_mode <= m;
    endtask
    task automatic fire(input logic [9:0] e);
        @(posedge pclk);
        events <= e;
        @(posedge pclk);
        events <= '0;
    endtask
    task automatic cnt(input logic [7:0] t, input logic [7:0] r);
        @(posedge pclk);
        cnt_upd <= {1'b1, t, 1'b1, r};
        @(posedge pclk);
        cnt_upd <= {1'b0, ~t, 1'b0, ~r};
    endtask
    // values beside a dropped strobe turn over so nothing stale is read
    task automatic misc(input logic hv, input logic [4:0] h, input logic cv,
                        input logic [4:0] c, input logic w, input logic r);
        @(posedge pclk);
        {filter_hit_valid, filter_hit, compare_len_load, compare_len_in} <= {hv, h, cv, c};
        {fifo_write_adv, fifo_read_adv} <= {w, r};
        @(posedge pclk);
        {filter_hit_valid, filter_hit, compare_len_load, compare_len_in} <= {1'b0, ~h, 1'b0, ~c};
        {fifo_write_adv, fifo_read_adv} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the can status register block
// assumes csr_regs, csr_engine_model and csr_chk are compiled before it
`default_nettype none
`include "csr_cfg.svh"
module tb_top
    import csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic           filter_hit_valid, compare_len_load, fifo_write_adv, fifo_read_adv;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata;
    logic [3:0]     pstrb, ix;
    logic [4:0]     data_bit_compare_count, fifo_first_buffer, filter_hit, compare_len_in;
    logic [4:0]     f, h, s5;
    logic [2:0]     buffer_area_size, op_mode;
    logic [5:0]     buffer_count;
    logic [7:0]     t, r;
    logic [63:0]    exp_q [$];
    logic [63:0]    n;
    csr_err_state_t err_state;
    csr_events_t    events;
    csr_cnt_upd_t   cnt_upd;
    int             i, fail_count, checked;
    logic [3:0]     fb [6] = '{4'h7, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0};
    logic [6:0]     cd [6] = '{7'h40, 7'h42, 7'h44, 7'h43, 7'h00, 7'h00};
    logic [5:0]     tbl [7] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20};
    csr_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .op_mode, .err_state, .events, .cnt_upd,
        .filter_hit_valid, .filter_hit, .compare_len_in, .compare_len_load, .fifo_write_adv,
        .fifo_read_adv, .data_bit_compare_count, .buffer_area_size, .buffer_count,
        .fifo_first_buffer, .irq);
    csr_engine_model eng (.pclk, .op_mode, .err_state, .events, .cnt_upd, .filter_hit_valid,
        .filter_hit, .compare_len_in, .compare_len_load, .fifo_write_adv, .fifo_read_adv);
    task automatic ck(input string s, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", s, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int m;
        m = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung access
        do begin
            @(posedge pclk);
            m++;
        end while (pready !== 1'b1);
        ck("ready wait", 32'h1, m);
        ck("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic [31:0] m = 32'hffffffff);
        exp_q.push_back({m, x & m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // read results are compared against the oldest note as they complete
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n = exp_q.pop_front();
            ck("prdata", n[31:0], prdata & n[63:32]);
        end
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #50000;
        fail_count++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        i = $urandom(32'h15a3235e);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) rd(12'h4 * i, (i == 1) ? 32'h40 : 32'h0);
        apb(1'b1, `CSR_OFS_ENABLES, 32'hffffffff);
        rd(`CSR_OFS_ENABLES, 32'hef);
        for (i = 0; i < 3; i++) eng.misc(1'b0, 5'h0, 1'b0, 5'h0, 1'b1, i == 0);
        rd(`CSR_OFS_FIFO_PTR, 32'h0301);
        for (i = 0; i < 6; i++) begin
            ix = $urandom_range(15, 0);
            if (i == 5) ix[3] = 1'b0;
            eng.fire((10'h200 >> i) | ix);
            rd(`CSR_OFS_FLAGS, 32'h1 << fb[i], 32'hff);
            ck("irq", 32'h1, {31'h0, irq});
            rd(`CSR_OFS_VECTOR, (i > 3) ? ix : cd[i], 32'h7f);
            apb(1'b1, `CSR_OFS_FLAGS, 32'hffffffff);
            rd(`CSR_OFS_FLAGS, 32'h1 << fb[i], 32'hff);
            apb(1'b1, `CSR_OFS_FLAGS, ~(32'h1 << fb[i]));
            rd(`CSR_OFS_FLAGS, 32'h0, 32'hff);
        end
        for (i = 0; i < 5; i++) begin
            s5 = 5'h1 << i;
            eng.lvl(s5, 3'h0);
            rd(`CSR_OFS_FLAGS, {18'h0, s5, s5[1] | s5[0], 3'h1, 5'h0}, 32'h3f20);
            rd(`CSR_OFS_VECTOR, 32'h41, 32'h7f);
            eng.lvl(5'h0, 3'h0);
            apb(1'b1, `CSR_OFS_FLAGS, 32'h0);
            rd(`CSR_OFS_FLAGS, 32'h0, 32'h3fff);
        end
        eng.fire(10'h140);
        rd(`CSR_OFS_VECTOR, 32'h42, 32'h7f);
        apb(1'b1, `CSR_OFS_FLAGS, 32'h0);
        t = $urandom;
        r = $urandom;
        eng.cnt(t, r);
        rd(`CSR_OFS_ERR_CNT, {t, r});
        eng.lvl(5'h0, `CSR_MODE_DISABLE);
        eng.fire(10'h100);
        rd(`CSR_OFS_FLAGS, 32'h40, 32'hff);
        rd(`CSR_OFS_ERR_CNT, {t, r});
        eng.lvl(5'h0, `CSR_MODE_CONFIG);
        rd(`CSR_OFS_ERR_CNT, 32'h0);
        rd(`CSR_OFS_FLAGS, 32'h40, 32'hff);
        eng.lvl(5'h0, 3'h0);
        apb(1'b1, `CSR_OFS_FLAGS, 32'h0);
        h = $urandom_range(15, 0);
        eng.misc(1'b1, h, 1'b1, 5'h11, 1'b0, 1'b0);
        rd(`CSR_OFS_VECTOR, {19'h0, h, 8'h0}, 32'h1f00);
        eng.misc(1'b1, 5'h10 | h, 1'b1, 5'h12 | h, 1'b0, 1'b0);
        rd(`CSR_OFS_VECTOR, {19'h0, h, 8'h0}, 32'h1f00);
        ck("compare", 32'h11, {27'h0, data_bit_compare_count});
        for (i = 0; i < 7; i++) begin
            f = $urandom_range(31, 0);
            apb(1'b1, `CSR_OFS_FIFO_CTL, {16'hffff, i[2:0], 8'hff, f});
            rd(`CSR_OFS_FIFO_CTL, {16'h0, i[2:0], 8'h0, f});
            ck("count", {26'h0, tbl[i]}, {26'h0, buffer_count});
        end
        apb(1'b1, `CSR_OFS_FIFO_CTL, 32'he000);
        rd(`CSR_OFS_FIFO_CTL, 32'hc000, 32'he000);
        apb(1'b1, `CSR_OFS_ENABLES, 32'h0);
        rd(`CSR_OFS_ENABLES, 32'h0);
        eng.fire(10'h100);
        rd(`CSR_OFS_FLAGS, 32'h40, 32'hff);
        ck("irq", 32'h0, {31'h0, irq});
        finish_test();
    end
endmodule
bind csr_regs csr_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .compare_len_in, .compare_len_load,
    .data_bit_compare_count, .buffer_area_size, .buffer_count, .fifo_first_buffer, .irq);
`default_nettype wire
